// *** core/smv_cfg.svh ***
`ifndef SMV_CFG_SVH
`define SMV_CFG_SVH

// channel positions of the upper sources
`define SMV_CH_EXT0 14
`define SMV_CH_EXT3 17
`define SMV_CH_ADC0 18
`define SMV_CH_I2C1 19
`define SMV_CH_BOD 20
`define SMV_CH_ADC1 21
`define SMV_CH_USB 22
`define SMV_NCH_LOW 14
`define SMV_NCH 32
// number of vectored priority slots
`define SMV_NSLOT 4
// larger variant carries channels 21 and 22
`define SMV_LARGE_VARIANT 1'b1
// reset values
`define SMV_RST_VECT 32'h0000_0000
`define SMV_RST_RAW 32'h0000_0000

`endif

// *** core/smv_pkg.sv ***
package smv_pkg;
  // priority hardware: idle or servicing one fetched vector
  typedef enum logic [0:0] {
    SMV_IDLE,
    SMV_IN_SERVICE
  } smv_svc_t;
  typedef logic [4:0] smv_chan_t;
  typedef logic [31:0] smv_word_t;
endpackage

// *** core/smv_top.sv ***
`timescale 1ns/1ps
`include "smv_cfg.svh"
// Functional notes
// - External lines 0 to 3 sit on channels 14 to 17, mask bit weight two to the channel.
// - Converter 0 end of conversion is channel 18, serial 1 state change 19, brown-out 20.
// - Converter 1 is channel 21 and USB is channel 22, present only on the larger variant.
// - USB controller requests and its DMA request are merged onto the one channel 22 line.
// - A vector read with no qualifying pending request returns the default vector register.
// - Request raised, core latches it, pipeline runs on, and only then is the vector read.
// - A request left unacknowledged stays pending and is presented again later.
// - A vector read returns the best enabled asserted slot address ranked above any slot in service, else the default.
// - A vector write releases the priority hardware and leaves the vector read value unchanged.
module smv_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`SMV_NCH_LOW-1:0] lower_irq,
  input wire logic external_irq_line_0,
  input wire logic external_irq_line_1,
  input wire logic external_irq_line_2,
  input wire logic external_irq_line_3,
  input wire logic adc0_eoc,
  input wire logic i2c1_state_chg,
  input wire logic brownout_detector,
  input wire logic adc1_eoc,
  input wire logic usb_irq,
  input wire logic usb_dma_irq,
  input wire smv_pkg::smv_word_t irq_enable,
  input wire smv_pkg::smv_word_t default_vector_register,
  input wire logic [`SMV_NSLOT-1:0] slot_en,
  input wire smv_pkg::smv_chan_t [`SMV_NSLOT-1:0] slot_chan,
  input wire smv_pkg::smv_word_t [`SMV_NSLOT-1:0] slot_addr,
  input wire logic vector_address_read,
  input wire logic vect_wr,
  output logic irq_q,
  output smv_pkg::smv_word_t vect_addr_q,
  output logic vect_valid_q,
  output smv_pkg::smv_word_t raw_q
);
  import smv_pkg::*;

  // lowest-numbered slot whose channel is enabled and asserted, below limit
  function automatic logic [2:0] pick_slot(input smv_word_t pend,
                                           input logic [`SMV_NSLOT-1:0] en,
                                           input smv_chan_t [`SMV_NSLOT-1:0] ch,
                                           input logic [2:0] limit);
    logic [2:0] sel;
    sel = 3'(`SMV_NSLOT);
    for (int i = `SMV_NSLOT - 1; i >= 0; i--) begin
      if (en[i] && pend[ch[i]] && (3'(i) < limit)) begin
        sel = 3'(i);
      end
    end
    return sel;
  endfunction

  smv_word_t raw_d;
  smv_word_t pend;
  smv_word_t vect_addr_d;
  logic irq_d;
  logic vect_valid_d;
  logic [2:0] limit;
  logic [2:0] sel;
  logic [2:0] svc_slot_d;
  logic [2:0] svc_slot_q;
  smv_svc_t svc_d;
  smv_svc_t svc_q;
  logic big;

  assign big = `SMV_LARGE_VARIANT;

  // source map, pending view, slot choice and next state
  always_comb begin
    raw_d = '0;
    raw_d[`SMV_NCH_LOW-1:0] = lower_irq;
    raw_d[`SMV_CH_EXT3:`SMV_CH_EXT0] = {external_irq_line_3, external_irq_line_2,
                                        external_irq_line_1, external_irq_line_0};
    raw_d[`SMV_CH_ADC0] = adc0_eoc;
    raw_d[`SMV_CH_I2C1] = i2c1_state_chg;
    raw_d[`SMV_CH_BOD] = brownout_detector;
    raw_d[`SMV_CH_ADC1] = big & adc1_eoc;
    raw_d[`SMV_CH_USB] = big & (usb_irq | usb_dma_irq);
    // level sources stay pending until cleared at the source
    pend = raw_q & irq_enable;
    limit = (svc_q == SMV_IN_SERVICE) ? svc_slot_q : 3'(`SMV_NSLOT);
    sel = pick_slot(pend, slot_en, slot_chan, limit);
    svc_d = svc_q;
    svc_slot_d = svc_slot_q;
    vect_addr_d = vect_addr_q;
    vect_valid_d = 1'b0;
    // while servicing, only higher slots may raise a new request
    if (svc_q == SMV_IN_SERVICE) begin
      irq_d = (sel != 3'(`SMV_NSLOT));
    end else begin
      irq_d = |pend;
    end
    case (svc_q)
      SMV_IDLE: begin
        if (vector_address_read) begin
          svc_d = SMV_IN_SERVICE;
          svc_slot_d = sel;
        end
      end
      SMV_IN_SERVICE: begin
        // write only releases the priority hardware
        if (vect_wr) begin
          svc_d = SMV_IDLE;
          svc_slot_d = 3'(`SMV_NSLOT);
        end else if (vector_address_read && sel != 3'(`SMV_NSLOT)) begin
          svc_slot_d = sel;
        end
      end
      default: svc_d = SMV_IDLE;
    endcase
    // fetch answered the cycle after the read
    if (vector_address_read) begin
      vect_valid_d = 1'b1;
      if (sel != 3'(`SMV_NSLOT)) begin
        vect_addr_d = slot_addr[sel[1:0]];
      end else begin
        vect_addr_d = default_vector_register;
      end
    end
  end

  // state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_q <= `SMV_RST_RAW;
      irq_q <= 1'b0;
      vect_addr_q <= `SMV_RST_VECT;
      vect_valid_q <= 1'b0;
      svc_q <= SMV_IDLE;
      svc_slot_q <= 3'(`SMV_NSLOT);
    end else begin
      raw_q <= raw_d;
      irq_q <= irq_d;
      vect_addr_q <= vect_addr_d;
      vect_valid_q <= vect_valid_d;
      svc_q <= svc_d;
      svc_slot_q <= svc_slot_d;
    end
  end

  // helper: request raised since the priority hardware was last released
  logic seen_d;
  logic seen_q;
  always_comb begin
    seen_d = seen_q;
    if (vect_wr) begin
      seen_d = 1'b0;
    end
    // a request in the release cycle wins
    if (irq_q) begin
      seen_d = 1'b1;
    end
  end

  // helper register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
    end
  end

  // checks
  AST_EXT_MAP: assert property (@(posedge sys_clk) disable iff (rst)
    1 |=> raw_q[17:14] == $past({external_irq_line_3, external_irq_line_2,
                                 external_irq_line_1, external_irq_line_0}))
    else $error("external lines not on channels 14 to 17");
  AST_MID_MAP: assert property (@(posedge sys_clk) disable iff (rst)
    1 |=> raw_q[20:18] == $past({brownout_detector, i2c1_state_chg, adc0_eoc}))
    else $error("channels 18 to 20 misplaced");
  AST_BIG_MAP: assert property (@(posedge sys_clk) disable iff (rst)
    adc1_eoc |=> raw_q[21] == big)
    else $error("converter 1 not on channel 21");
  AST_USB_MERGE: assert property (@(posedge sys_clk) disable iff (rst)
    (usb_irq ^ usb_dma_irq) |=> raw_q[22] == big && raw_q[31:23] == 9'h000)
    else $error("usb request not merged on channel 22");
  AST_DEFAULT: assert property (@(posedge sys_clk) disable iff (rst)
    vector_address_read && sel == 3'(`SMV_NSLOT)
    |=> vect_valid_q && vect_addr_q == $past(default_vector_register))
    else $error("spurious fetch did not return default vector");
  AST_READ_ORDER: assert property (@(posedge sys_clk) disable iff (rst)
    vect_valid_q == $past(vector_address_read))
    else $error("vector delivery not tied to a read");
  AST_REQ_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
    svc_q == SMV_IDLE && vector_address_read |-> seen_q)
    else $error("vector read before any request");
  AST_PENDING_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
    svc_q == SMV_IDLE && |(raw_q & irq_enable) |=> irq_q)
    else $error("pending request not presented");
  AST_SLOT_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
    vector_address_read && sel != 3'(`SMV_NSLOT)
    |=> vect_addr_q == $past(slot_addr[sel[1:0]]))
    else $error("vector read returned wrong slot address");
  AST_SVC_SLOT: assert property (@(posedge sys_clk) disable iff (rst)
    svc_q == SMV_IDLE && vector_address_read
    |=> svc_q == SMV_IN_SERVICE && svc_slot_q == $past(sel))
    else $error("priority hardware did not record fetched slot");
  AST_TOP_SLOT_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    svc_q == SMV_IN_SERVICE && svc_slot_q == 3'h0 |=> !irq_q)
    else $error("request raised while top slot in service");
  AST_WRITE_NOCHG: assert property (@(posedge sys_clk) disable iff (rst)
    vect_wr && !vector_address_read |=> $stable(vect_addr_q))
    else $error("vector write changed read value");
  AST_WR_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
    svc_q == SMV_IN_SERVICE && vect_wr |=> svc_q == SMV_IDLE)
    else $error("vector write did not release priority hardware");

  // scenario covers
  COV_SPURIOUS: cover property (@(posedge sys_clk) disable iff (rst)
    irq_q ##[1:8] (vector_address_read && sel == 3'(`SMV_NSLOT)));
  COV_SLOT: cover property (@(posedge sys_clk) disable iff (rst)
    vector_address_read && sel == 3'h0);
  COV_RELEASE: cover property (@(posedge sys_clk) disable iff (rst)
    svc_q == SMV_IN_SERVICE ##1 vect_wr ##2 irq_q);
endmodule

// *** dv/smv_core_model.sv ***
`timescale 1ns/1ps
// core side: latch request, run pipeline, fetch vector, stay in handler till write
module smv_core_model #(
  parameter int PIPE = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic irq_q,
  input wire logic vect_wr,
  input wire logic mask_set,
  input wire logic mask_clr,
  output logic vector_address_read,
  output logic [1:0] status_q,
  output logic [1:0] saved_status_word_q
);
  logic [1:0] ph_q;
  logic [3:0] cnt_q;
  logic [1:0] ph_d;
  logic [3:0] cnt_d;
  logic read_d;
  logic [1:0] status_d;
  logic [1:0] saved_d;
  // status bits: [1] fast mask, [0] irq mask
  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q + 4'h1;
    read_d = 1'b0;
    saved_d = saved_status_word_q;
    status_d = status_q;
    // masking instruction completes even with a request latched
    if (mask_set) begin
      status_d = 2'h3;
    end else if (mask_clr) begin
      status_d = 2'h0;
    end
    case (ph_q)
      2'h0: begin
        // request seen while irq mask was clear is taken
        if (irq_q && !status_q[0]) begin
          ph_d = 2'h1;
          cnt_d = 4'h0;
          // saved status keeps masks set by that instruction
          saved_d = status_d;
          // entry masks irq, fast mask left as it stands
          status_d = {status_d[1], 1'b1};
        end
      end
      2'h1: begin
        // pipeline runs on before the vector read
        if (cnt_q == 4'(PIPE)) begin
          ph_d = 2'h2;
          read_d = 1'b1;
        end
      end
      default: begin
        // return restores saved status, fast mask included
        if (vect_wr) begin
          ph_d = 2'h0;
          status_d = saved_status_word_q;
        end
      end
    endcase
  end

  // model registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
      vector_address_read <= 1'b0;
      status_q <= 2'h0;
      saved_status_word_q <= 2'h0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      vector_address_read <= read_d;
      status_q <= status_d;
      saved_status_word_q <= saved_d;
    end
  end
endmodule

// *** dv/smv_top_tb_top.sv ***
`timescale 1ns/1ps
module smv_top_tb_top;
  import smv_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] src = 10'h0;
  smv_word_t irq_enable = 32'h0;
  smv_word_t default_vector_register = 32'hfeed_0bad;
  logic [3:0] slot_en = 4'h0;
  smv_chan_t [3:0] slot_chan = '0;
  smv_word_t [3:0] slot_addr = '0;
  logic vector_address_read, vect_wr = 1'b0;
  logic mask_set = 1'b0;
  logic mask_clr = 1'b0;
  logic [1:0] core_sw;
  logic [1:0] saved_sw;
  logic irq_q, vect_valid_q;
  smv_word_t vect_addr_q, raw_q;
  int n_errors = 0;
  int n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  smv_top DUT (.sys_clk(sys_clk), .rst(rst), .lower_irq(14'h0),
    .external_irq_line_0(src[0]), .external_irq_line_1(src[1]),
    .external_irq_line_2(src[2]), .external_irq_line_3(src[3]),
    .adc0_eoc(src[4]), .i2c1_state_chg(src[5]), .brownout_detector(src[6]),
    .adc1_eoc(src[7]), .usb_irq(src[8]), .usb_dma_irq(src[9]),
    .irq_enable(irq_enable), .default_vector_register(default_vector_register),
    .slot_en(slot_en), .slot_chan(slot_chan), .slot_addr(slot_addr),
    .vector_address_read(vector_address_read), .vect_wr(vect_wr), .irq_q(irq_q),
    .vect_addr_q(vect_addr_q), .vect_valid_q(vect_valid_q), .raw_q(raw_q));
  smv_core_model #(.PIPE(3)) core (.sys_clk(sys_clk), .rst(rst), .irq_q(irq_q),
    .vect_wr(vect_wr), .mask_set(mask_set), .mask_clr(mask_clr),
    .vector_address_read(vector_address_read), .status_q(core_sw),
    .saved_status_word_q(saved_sw));
  task close_out;
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input smv_word_t got, input smv_word_t exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait on fetch pulse (sel=1) or request (sel=0)
  task wait_sig(input bit sel);
    for (int i = 0; i < 60; i++) begin
      if ((sel ? vect_valid_q : irq_q) === 1'b1) return;
      step(1);
    end
    n_errors++;
    close_out();
  endtask
  task end_handler;
    vect_wr = 1'b1;
    step(1);
    vect_wr = 1'b0;
  endtask
  // each upper source lands on its own channel bit, usb and dma share one
  task t_map;
    for (int i = 0; i < 10; i++) begin
      src = 10'h1 << i;
      step(2);
      chk(raw_q, 32'h1 << (i < 9 ? 14 + i : 22));
    end
    src = 10'h0;
    step(2);
    chk(raw_q, 32'h0);
  endtask
  // vectored fetch, unacked return, write leaves read value alone
  task t_vec;
    slot_en = 4'h1;
    slot_chan[0] = 5'h0e;
    slot_addr[0] = 32'h0000_1230;
    irq_enable = 32'h0000_4000;
    src = 10'h1;
    wait_sig(1'b1);
    chk(vect_addr_q, 32'h0000_1230);
    step(2);
    end_handler();
    chk(vect_addr_q, 32'h0000_1230);
    wait_sig(1'b1);
    chk(vect_addr_q, 32'h0000_1230);
    src = 10'h0;
    step(2);
    end_handler();
    step(3);
  endtask
  // request withdrawn between latch and fetch gives default
  task t_spur;
    src = 10'h1;
    wait_sig(1'b0);
    src = 10'h0;
    irq_enable = 32'h0;
    wait_sig(1'b1);
    chk(vect_addr_q, default_vector_register);
    step(1);
    end_handler();
    step(3);
  endtask
  // request latched during a masking instruction: taken, masks saved and restored
  task t_mask;
    smv_word_t hits;
    hits = 32'h0;
    irq_enable = 32'h0000_4000;
    src = 10'h1;
    wait_sig(1'b0);
    mask_set = 1'b1;
    step(1);
    mask_set = 1'b0;
    wait_sig(1'b1);
    chk(vect_addr_q, 32'h0000_1230);
    chk({30'h0, saved_sw}, 32'h3);
    chk({30'h0, core_sw}, 32'h3);
    step(2);
    end_handler();
    chk({30'h0, core_sw}, 32'h3);
    for (int i = 0; i < 12; i++) begin
      if (vect_valid_q !== 1'b0) hits++;
      step(1);
    end
    chk(hits, 32'h0);
    mask_clr = 1'b1;
    step(1);
    mask_clr = 1'b0;
    wait_sig(1'b1);
    chk(vect_addr_q, 32'h0000_1230);
    chk({30'h0, core_sw}, 32'h1);
    src = 10'h0;
    step(2);
    end_handler();
    step(3);
  endtask
  initial begin
    step(20);
    rst = 1'b0;
    step(1);
    t_map();
    t_vec();
    t_spur();
    t_mask();
    close_out();
  end
endmodule
